// ### design/mpr_ctrl.v
// host controller for mpr calibration reads and bank activate/precharge
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "mpr_ctrl_consts.vh"
//
// Contract
// - precharge all, wait trp, then mr3
// - wait tmrd and tmod before mpr read
// - no writes while mpr enabled
// - mpr read: a1:0 zero, a2 zero, a12 high; code drives a2 high for the upper chop-four nibble and a12 low for chop four
// - reads repeat; wait tmprr before mr3
// - clearing mpr restores normal, wait tmrd/tmod
// - precharge before activating another row
// - other bank access allowed during auto precharge
// - idle bank needs activate before read
// - a12 low chop four, high eight
// - only reads while mpr enabled
// - mpr reads only after dll lock
module mpr_ctrl (
  // clock and reset
  input wire i_clk,
  input wire i_rstn,
  // software register port
  input wire [3:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // device status
  input wire i_dll_locked,
  // device command/address pins
  output reg o_cs_n,
  output reg o_ras_n,
  output reg o_cas_n,
  output reg o_we_n,
  output reg [2:0] o_ba,
  output reg [13:0] o_a,
  // read data pins
  input wire [7:0] i_dq
);
  localparam S_IDLE = 3'h0;
  localparam S_WAIT = 3'h1;
  localparam S_LAT = 3'h2;
  localparam S_CAP = 3'h3;
  localparam S_ERR = 3'h4;

  // cycle counts held at 32 bits, then cut on purpose to the counter width
  localparam [31:0] RP_CYC = `N_RP;
  localparam [31:0] MOD_CYC = `N_MOD;
  localparam [31:0] MRD_CYC = `N_MRD;
  localparam [31:0] MPRR_CYC = `N_MPRR;
  // a mode write must honour both tmrd and tmod, so the longer one is kept
  localparam [31:0] MRS_CYC = (MOD_CYC > MRD_CYC) ? MOD_CYC : MRD_CYC;

  reg [2:0] state_r;
  reg [3:0] wait_r;
  reg [7:0] lat_r;
  reg [7:0] lcnt_r;
  reg mpr_on_r;
  reg err_r;

  reg bl8_r;
  reg nib_r;

  reg [13:0] row_r;
  reg [7:0] open_r;
  reg [7:0] rowv_r [0:7];
  reg [13:0] rows_r [0:7];
  reg [3:0] trp_r [0:7];

  reg mprr_r;
  reg [3:0] mcnt_r;
  wire cap_busy;
  wire cap_done;
  wire [7:0] cap_data;
  wire [31:0] ctrl_w;
  wire [2:0] op_w;
  wire [2:0] bank_w;
  wire go_w;
  wire [31:0] status_w;

  assign ctrl_w = i_wdata;
  assign op_w = ctrl_w[`CTRL_OP_MSB:`CTRL_OP_LSB];
  assign bank_w = ctrl_w[`CTRL_BANK_MSB:`CTRL_BANK_LSB];
  assign go_w = i_wr && (i_addr == `REG_CTRL) && ctrl_w[`CTRL_GO] &&
                (state_r == S_IDLE);

  // true when every bank has its precharge period behind it
  function all_rp_done;
    input [31:0] dummy;
    integer k;
    begin
      all_rp_done = 1'b1;
      for (k = 0; k < 8; k = k + 1) begin
        if (trp_r[k] != 4'h0)
          all_rp_done = 1'b0;
      end
    end
  endfunction

  // legality check of a requested operation against current state
  function legal_op;
    input [2:0] op;
    input [2:0] bk;
    begin
      case (op)
        `OP_MPR_ON: begin
          // every bank idle with trp behind it before mr3 is touched
          legal_op = !mpr_on_r && (open_r == 8'h00) && all_rp_done(0);
        end
        `OP_MPR_RD: begin
          legal_op = mpr_on_r && i_dll_locked;
        end
        `OP_MPR_OFF: begin
          // leaving too early would cut the burst still on the wire
          legal_op = mpr_on_r && !mprr_r && !cap_busy;
        end
        `OP_ACT: begin
          legal_op = !mpr_on_r && !open_r[bk] && (trp_r[bk] == 4'h0);
        end
        `OP_PRE: begin
          legal_op = !mpr_on_r;
        end
        `OP_PREA: begin
          legal_op = !mpr_on_r;
        end
        `OP_READ: begin
          // no auto precharge is ever sent, so no bank is busy behind a read
          legal_op = !mpr_on_r && open_r[bk];
        end
        default: begin
          legal_op = 1'b0;
        end
      endcase
    end
  endfunction

  burst_capture u_cap (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_start(state_r == S_LAT && lcnt_r == 8'h00),
    .i_bl8(bl8_r),
    .i_nib(nib_r),
    .i_dq0(i_dq[0]),
    .o_data(cap_data),
    .o_busy(cap_busy),
    .o_done(cap_done)
  );

  // true when the operation closes bank idx: a single precharge or precharge all
  function closes_bank;
    input [2:0] op;
    input [2:0] bk;
    input [31:0] idx;
    begin
      closes_bank = (op == `OP_PREA) || ((op == `OP_PRE) && ({29'h0, bk} == idx));
    end
  endfunction

  // per-bank precharge timers; a fresh precharge restarts the count
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_bank
      always @(posedge i_clk) begin
        if (!i_rstn) begin
          trp_r[g] <= 4'h0;
        end else if (go_w && legal_op(op_w, bank_w) && closes_bank(op_w, bank_w, g)) begin
          trp_r[g] <= RP_CYC[3:0];
        end else if (trp_r[g] != 4'h0) begin
          trp_r[g] <= trp_r[g] - 4'h1;
        end
      end
      always @(posedge i_clk) begin
        if (!i_rstn) begin
          open_r[g] <= 1'b0;
          rows_r[g] <= 14'h0000;
        end else if (go_w && legal_op(op_w, bank_w)) begin
          if (op_w == `OP_ACT && bank_w == g) begin
            open_r[g] <= 1'b1;
            rows_r[g] <= row_r;
          end else if (closes_bank(op_w, bank_w, g)) begin
            open_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // command sequencing
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      state_r <= S_IDLE;
      wait_r <= 4'h0;
      lcnt_r <= 8'h00;
      mpr_on_r <= 1'b0;
      err_r <= 1'b0;
      bl8_r <= 1'b1;
      nib_r <= 1'b0;
      mprr_r <= 1'b0;
      mcnt_r <= 4'h0;
      o_cs_n <= 1'b1;
      o_ras_n <= 1'b1;
      o_cas_n <= 1'b1;
      o_we_n <= 1'b1;
      o_ba <= 3'h0;
      o_a <= 14'h0000;
    end else begin
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= `CMD_NOP;
      // tmprr window after each mpr burst; a new burst end wins over expiry
      if (mcnt_r != 4'h0) begin
        mcnt_r <= mcnt_r - 4'h1;
      end else begin
        mprr_r <= 1'b0;
      end
      if (cap_done && mpr_on_r) begin
        mprr_r <= 1'b1;
        mcnt_r <= MPRR_CYC[3:0];
      end

      // software clears the error flag by writing status
      if (i_wr && i_addr == `REG_STATUS) begin
        err_r <= 1'b0;
      end

      case (state_r)
        S_IDLE: begin
          if (go_w) begin
            if (!legal_op(op_w, bank_w)) begin
              err_r <= 1'b1;
            end else begin
              bl8_r <= ctrl_w[`CTRL_BL8];
              nib_r <= ctrl_w[`CTRL_NIB];
              o_a <= 14'h0000;
              o_ba <= bank_w;
              state_r <= S_IDLE;
              case (op_w)
                `OP_MPR_ON, `OP_MPR_OFF: begin
                  {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= `CMD_MRS;
                  o_ba <= `MR3_BA;
                  o_a[`MR3_MPR_BIT] <= (op_w == `OP_MPR_ON);
                  mpr_on_r <= (op_w == `OP_MPR_ON);
                  wait_r <= MRS_CYC[3:0];
                  state_r <= S_WAIT;
                end
                `OP_ACT: begin
                  {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= `CMD_ACT;
                  o_a <= row_r;
                end
                `OP_PRE, `OP_PREA: begin
                  {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= `CMD_PRE;
                  o_a[10] <= (op_w == `OP_PREA);
                end
                default: begin
                  // mpr read: a1:0=0, a2 picks nibble, a12 picks length
                  {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= `CMD_RD;
                  o_a[2] <= ctrl_w[`CTRL_NIB] && !ctrl_w[`CTRL_BL8];
                  o_a[12] <= ctrl_w[`CTRL_BL8];
                  if (op_w == `OP_READ)
                    o_a[9:0] <= row_r[9:0] & 10'h3F8;
                  lcnt_r <= lat_r;
                  state_r <= S_LAT;
                end
              endcase
            end
          end
        end
        S_WAIT: begin
          if (wait_r == 4'h0)
            state_r <= S_IDLE;
          else
            wait_r <= wait_r - 4'h1;
        end
        S_LAT: begin
          if (lcnt_r == 8'h00)
            state_r <= S_CAP;
          else
            lcnt_r <= lcnt_r - 8'h01;
        end
        S_CAP: begin
          if (cap_done)
            state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // status word: open banks, dll, error, tmprr pending, mpr on, busy
  assign status_w = {
    16'h0000,
    open_r,
    3'h0,
    i_dll_locked,
    err_r,
    mprr_r,
    mpr_on_r,
    (state_r != S_IDLE)
  };

  // software-written registers
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      row_r <= 14'h0000;
      lat_r <= `LAT_RST;
    end else if (i_wr) begin
      if (i_addr == `REG_ROW)
        row_r <= i_wdata[13:0];
      if (i_addr == `REG_LAT)
        lat_r <= i_wdata[7:0];
    end
  end

  // read data one cycle after strobe; unmapped reads zero
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `REG_STATUS: o_rdata <= status_w;
        `REG_ROW: o_rdata <= {18'h00000, row_r};
        `REG_CAPTURE: o_rdata <= {24'h000000, cap_data};
        `REG_LAT: o_rdata <= {24'h000000, lat_r};
        default: o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end
endmodule

// ### design/mpr_ctrl_consts.vh
// constants for the mpr calibration and bank controller
`ifndef MPR_CTRL_CONSTS_VH
`define MPR_CTRL_CONSTS_VH
// register offsets (word index on the software port)
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_ROW 4'h2
`define REG_CAPTURE 4'h3
`define REG_LAT 4'h4
// control fields
`define CTRL_GO 0
`define CTRL_OP_LSB 1
`define CTRL_OP_MSB 3
`define CTRL_BANK_LSB 4
`define CTRL_BANK_MSB 6
`define CTRL_BL8 7
`define CTRL_NIB 8
// operations
`define OP_MPR_ON 3'h1
`define OP_MPR_RD 3'h2
`define OP_MPR_OFF 3'h3
`define OP_ACT 3'h4
`define OP_PRE 3'h5
`define OP_PREA 3'h6
`define OP_READ 3'h7
// command encodings {cs_n, ras_n, cas_n, we_n}
`define CMD_NOP 4'h7
`define CMD_MRS 4'h0
`define CMD_ACT 4'h3
`define CMD_PRE 4'h2
`define CMD_RD 4'h5
// mode register 3 select and mpr enable bit
`define MR3_BA 3'h3
`define MR3_MPR_BIT 2
// timing in ns and derived cycles at 50 MHz (20 ns)
`define CLK_NS 20
`define T_RP_NS 15
`define T_MOD_NS 15
`define T_MPRR_NS 20
`define N_RP ((`T_RP_NS + `CLK_NS - 1) / `CLK_NS)
`define N_MOD_NS ((`T_MOD_NS + `CLK_NS - 1) / `CLK_NS)
`define N_MRD 4
`define N_MOD 12
`define N_MPRR 1
// reset values
`define LAT_RST 8'h06
`endif

// ### design/burst_capture.v
// captures read data beats into a byte, beat n into bit n, or bit n+4 for the upper chop-four nibble
`timescale 1ns/1ps
module burst_capture (
  // clock and reset
  input wire i_clk,
  input wire i_rstn,
  // control
  input wire i_start,
  input wire i_bl8,
  input wire i_nib,
  // data beat from dq0
  input wire i_dq0,
  // result
  output reg [7:0] o_data,
  output wire o_busy,
  output reg o_done
);
  reg [3:0] cnt_r;
  reg [2:0] pos_r;
  reg [7:0] acc_r;
  assign o_busy = (cnt_r != 4'h0);
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt_r <= 4'h0;
      pos_r <= 3'h0;
      acc_r <= 8'h00;
      o_data <= 8'h00;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        cnt_r <= i_bl8 ? 4'h8 : 4'h4;
        pos_r <= (i_nib && !i_bl8) ? 3'h4 : 3'h0;
        acc_r <= 8'h00;
      end else if (cnt_r != 4'h0) begin
        acc_r[pos_r] <= i_dq0;
        pos_r <= pos_r + 3'h1;
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          o_data <= acc_r | ({7'h00, i_dq0} << pos_r);
          o_done <= 1'b1;
        end
      end
    end
  end
endmodule

// ### testbench/mpr_ctrl_checker.sv
// pin-level assertions for the mpr controller
`timescale 1ns/1ps
`include "mpr_ctrl_consts.vh"
module mpr_ctrl_checker (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_dll_locked,
  input wire logic o_cs_n,
  input wire logic o_ras_n,
  input wire logic o_cas_n,
  input wire logic o_we_n,
  input wire logic [2:0] o_ba,
  input wire logic [13:0] o_a
);
  wire [3:0] cmd = {o_cs_n, o_ras_n, o_cas_n, o_we_n};
  logic mpr_r;
  logic [7:0] open_r;
  logic [4:0] since_mrs_r;
  // mirror of device state, rebuilt from the command pins only
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      mpr_r <= 1'b0;
      open_r <= 8'h00;
      since_mrs_r <= 5'h1F;
    end else begin
      if (cmd == `CMD_MRS)
        since_mrs_r <= 5'h00;
      else if (since_mrs_r != 5'h1F)
        since_mrs_r <= since_mrs_r + 5'h01;
      if (cmd == `CMD_MRS && o_ba == `MR3_BA)
        mpr_r <= o_a[`MR3_MPR_BIT];
      if (cmd == `CMD_ACT)
        open_r[o_ba] <= 1'b1;
      if (cmd == `CMD_PRE)
        open_r <= o_a[10] ? 8'h00 : (open_r & ~(8'h01 << o_ba));
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  no_write_mpr_a: assert property (mpr_r |-> cmd != 4'h4)
    else $error("write issued in mpr mode");
  mpr_only_read_a: assert property (mpr_r && cmd != `CMD_NOP && cmd != `CMD_MRS
    |-> cmd == `CMD_RD) else $error("non-read command in mpr mode");
  mpr_col_a: assert property (mpr_r && cmd == `CMD_RD
    |-> o_a[1:0] == 2'h0 && !(o_a[12] && o_a[2])) else $error("bad mpr read column");
  mr3_loc_a: assert property (cmd == `CMD_MRS && o_ba == `MR3_BA && o_a[2]
    |-> o_a[1:0] == 2'h0) else $error("reserved mpr location");
  mpr_idle_a: assert property (cmd == `CMD_MRS && o_ba == `MR3_BA && o_a[2]
    |-> open_r == 8'h00) else $error("mpr enabled with open bank");
  mod_wait_a: assert property (cmd != `CMD_NOP |-> since_mrs_r >= 5'h0B)
    else $error("command too soon after mode write");
  act_closed_a: assert property (cmd == `CMD_ACT |-> !open_r[o_ba])
    else $error("activate on open bank");
  rd_open_a: assert property (cmd == `CMD_RD && !mpr_r |-> open_r[o_ba])
    else $error("read to idle bank");
  dll_rd_a: assert property (cmd == `CMD_RD && mpr_r |-> i_dll_locked)
    else $error("mpr read without dll lock");
  mpr_rd_c: cover property (cmd == `CMD_RD && mpr_r);
  act_c: cover property (cmd == `CMD_ACT);
  pre_c: cover property (cmd == `CMD_PRE);
endmodule
bind mpr_ctrl mpr_ctrl_checker i_chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_dll_locked(i_dll_locked), .o_cs_n(o_cs_n), .o_ras_n(o_ras_n), .o_cas_n(o_cas_n),
  .o_we_n(o_we_n), .o_ba(o_ba), .o_a(o_a));

// ### testbench/mem_model.sv
// behavioural memory device answering calibration reads
`timescale 1ns/1ps
`include "mpr_ctrl_consts.vh"
module mem_model #(parameter int RL = 6) (
  input wire logic i_clk,
  input wire logic [3:0] i_cmd,
  input wire logic [2:0] i_ba,
  input wire logic [13:0] i_a,
  output logic [7:0] o_dq
);
  logic mpr_r = 1'b0;
  logic [7:0] open_r = 8'h00;
  int dly = 0;
  int left = 0;
  logic [2:0] beat = 3'h0;
  initial o_dq = 8'h5A;
  always @(posedge i_clk) begin
    // idle bus keeps changing so stale data never looks valid
    o_dq <= ~o_dq;
    if (dly > 0)
      dly <= dly - 1;
    if (i_cmd == `CMD_MRS && i_ba == `MR3_BA)
      mpr_r <= i_a[`MR3_MPR_BIT];
    if (i_cmd == `CMD_ACT)
      open_r[i_ba] <= 1'b1;
    if (i_cmd == `CMD_PRE)
      open_r <= i_a[10] ? 8'h00 : (open_r & ~(8'h01 << i_ba));
    if (i_cmd == `CMD_RD && mpr_r) begin
      // auto precharge bit ignored here
      dly <= RL;
      left <= i_a[12] ? 8 : 4;
      beat <= {i_a[2] & ~i_a[12], 2'b00};
    end else if (dly <= 1 && left != 0) begin
      o_dq <= {8{beat[0]}};
      beat <= beat + 3'h1;
      left <= left - 1;
    end
  end
endmodule

// ### testbench/tb_top.sv
// self-checking bench for the mpr controller
`timescale 1ns/1ps
`include "mpr_ctrl_consts.vh"
module tb_top;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_dll_locked = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0, rdat;
  wire [31:0] o_rdata;
  wire o_cs_n, o_ras_n, o_cas_n, o_we_n;
  wire [2:0] o_ba;
  wire [13:0] o_a;
  wire [7:0] dq;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  // ctrl[31:20] err[16] capture[15:8] mask[7:0]
  logic [31:0] rows [0:16] = '{32'h0290_0000, 32'h0291_0000, 32'h0AF0_0000, 32'h0DF1_0000,
    32'h0390_0000, 32'h03B0_0000, 32'h03B0_0000, 32'h0390_0000, 32'h0031_0000,
    32'h00D0_0000, 32'h0030_0000, 32'h0191_0000, 32'h0850_AAFF, 32'h0050_0A0F,
    32'h1050_A0F0, 32'h0070_0000, 32'h0AF1_0000};
  mpr_ctrl i_mpr_ctrl (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_dll_locked(i_dll_locked),
    .o_cs_n(o_cs_n), .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_we_n(o_we_n),
    .o_ba(o_ba), .o_a(o_a), .i_dq(dq));
  mem_model i_mem_model (.i_clk(i_clk), .i_cmd({o_cs_n, o_ras_n, o_cas_n, o_we_n}),
    .i_ba(o_ba), .i_a(o_a), .o_dq(dq));
  initial forever #10 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rdat = o_rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_checks++;
    if ((got & m) !== (exp & m)) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // clears the error flag first so each operation is judged alone
  task automatic run_op(input logic [31:0] ctrl);
    wr(`REG_STATUS, 32'h0);
    wr(`REG_CTRL, ctrl);
    for (int i = 0; i < 40; i++) begin
      rd(`REG_STATUS);
      if (rdat[0] === 1'b0)
        break;
    end
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(`REG_LAT);
    chk(rdat, 32'h6, 32'hFF);
    rd(`REG_STATUS);
    chk(rdat, 32'h0, 32'hFF0F);
    $display("reset test done");
    for (int i = 0; i < 17; i++) begin
      run_op({20'h0, rows[i][31:20]});
      chk(rdat, {28'h0, rows[i][16], 3'h0}, 32'h9);
      rd(`REG_CAPTURE);
      chk(rdat, {24'h0, rows[i][15:8]}, {24'h0, rows[i][7:0]});
      $display("row %0d done", i);
    end
    run_op(32'h003);
    @(posedge i_clk);
    i_dll_locked <= 1'b0;
    run_op(32'h085);
    chk(rdat, 32'h8, 32'h9);
    @(posedge i_clk);
    i_dll_locked <= 1'b1;
    run_op(32'h007);
    chk(rdat, 32'h0, 32'h9);
    rd(4'hF);
    chk(rdat, 32'h0, 32'hFFFFFFFF);
    $display("refusal tests done");
    complete_run;
  end
endmodule
